//--- eelc_top.sv
`timescale 1ns/1ps

module eelc_top #(
  parameter int NLINES = eelc_pkg::NLINES_DEF,
  parameter int NEXT   = eelc_pkg::NEXT_DEF,
  parameter int NPINS  = eelc_pkg::NPINS_DEF
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // register port
  input  wire eelc_pkg::eelc_bus_req_t    bus_req,
  output logic [eelc_pkg::DW-1:0]         rdata,
  // event sources
  input  wire logic [NPINS-1:0]           gpio_in,
  input  wire logic [NLINES-NEXT-1:0]     int_src,
  // requests
  output logic [NLINES-1:0]               irq_line,
  output logic [NLINES-1:0]               evt_req,
  output logic                            wake_req,
  output logic                            irq
);

  localparam int SELW  = eelc_pkg::SELW;
  localparam int NWORD = NEXT / eelc_pkg::SEL_PER_WD;

  // zero-extend a line vector to a bus word
  function automatic logic [eelc_pkg::DW-1:0] zx(input logic [NLINES-1:0] v);
    zx = '0;
    zx[NLINES-1:0] = v;
  endfunction

  // true when the address falls in the pin-selector words
  function automatic logic sel_hit(input logic [eelc_pkg::AW-1:0] a);
    sel_hit = (a >= eelc_pkg::OFS_SEL0) && (a <= eelc_pkg::OFS_SEL3) && (a[1:0] == 2'h0);
  endfunction

  // configuration and status state
  logic [NLINES-1:0]       imask_r,  imask_nxt;
  logic [NLINES-1:0]       emask_r,  emask_nxt;
  logic [NLINES-1:0]       rtrig_r,  rtrig_nxt;
  logic [NLINES-1:0]       ftrig_r,  ftrig_nxt;
  logic [NLINES-1:0]       pend_r,   pend_nxt;
  logic [NLINES-1:0]       sstat_r,  sstat_nxt;
  logic [NLINES-1:0]       smask_r,  smask_nxt;
  logic [SELW-1:0]         sel_r     [NEXT];
  logic [SELW-1:0]         sel_nxt   [NEXT];
  logic [eelc_pkg::DW-1:0] rdata_nxt;
  logic [NLINES-1:0]       irq_line_nxt;
  logic [NLINES-1:0]       evt_nxt;
  logic                    wake_nxt;
  logic                    irq_nxt;

  // edge capture and detection
  logic [NEXT-1:0]         rise_tog, fall_tog;
  logic [NEXT-1:0]         rise_s1, rise_s2, rise_s3;
  logic [NEXT-1:0]         fall_s1, fall_s2, fall_s3;
  logic [NLINES-NEXT-1:0]  int_prev_r;
  logic [NLINES-1:0]       rise_ev, fall_ev, hit;
  logic [NLINES-1:0]       pend_clr;
  logic                    rd_sstat;
  int                      wi;

  // pin selection and asynchronous capture per external line; each pin edge flips a
  // toggle, so a pulse far narrower than clk still leaves one rise and one fall mark.
  // limitation: reprogramming a selector can itself produce a spurious edge.
  for (genvar g = 0; g < NEXT; g++) begin : g_ext
    logic pin;
    logic rt;
    logic ft;
    assign pin = (sel_r[g] < NPINS) ? gpio_in[sel_r[g]] : 1'b0;

    always_ff @(posedge pin or negedge nrst) begin
      if (!nrst) begin
        rt <= 1'b0;
      end else begin
        rt <= ~rt;
      end
    end

    always_ff @(negedge pin or negedge nrst) begin
      if (!nrst) begin
        ft <= 1'b0;
      end else begin
        ft <= ~ft;
      end
    end

    assign rise_tog[g] = rt;
    assign fall_tog[g] = ft;
  end

  // two-stage synchronisers plus a history stage for toggle compare
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_s1    <= '0;
      rise_s2    <= '0;
      rise_s3    <= '0;
      fall_s1    <= '0;
      fall_s2    <= '0;
      fall_s3    <= '0;
      int_prev_r <= '0;
    end else begin
      rise_s1    <= rise_tog;
      rise_s2    <= rise_s1;
      rise_s3    <= rise_s2;
      fall_s1    <= fall_tog;
      fall_s2    <= fall_s1;
      fall_s3    <= fall_s2;
      int_prev_r <= int_src;
    end
  end

  // edge events; internal sources share clk and need no synchroniser
  always_comb begin
    rise_ev = '0;
    fall_ev = '0;
    rise_ev[NEXT-1:0]      = rise_s2 ^ rise_s3;
    fall_ev[NEXT-1:0]      = fall_s2 ^ fall_s3;
    rise_ev[NLINES-1:NEXT] = int_src & ~int_prev_r;
    fall_ev[NLINES-1:NEXT] = ~int_src & int_prev_r;
    hit = (rise_ev & rtrig_r) | (fall_ev & ftrig_r);
  end

  // register port decode and next state of all software-visible state
  always_comb begin
    imask_nxt = imask_r;
    emask_nxt = emask_r;
    rtrig_nxt = rtrig_r;
    ftrig_nxt = ftrig_r;
    smask_nxt = smask_r;
    sel_nxt   = sel_r;
    pend_clr  = '0;
    rdata_nxt = '0;
    rd_sstat  = bus_req.rd && (bus_req.addr == eelc_pkg::OFS_SSTAT);
    wi        = (int'(bus_req.addr) - int'(eelc_pkg::OFS_SEL0)) / 4;
    if (bus_req.wr) begin
      case (bus_req.addr)
        eelc_pkg::OFS_IMASK: imask_nxt = bus_req.wdata[NLINES-1:0];
        eelc_pkg::OFS_EMASK: emask_nxt = bus_req.wdata[NLINES-1:0];
        eelc_pkg::OFS_RTRIG: rtrig_nxt = bus_req.wdata[NLINES-1:0];
        eelc_pkg::OFS_FTRIG: ftrig_nxt = bus_req.wdata[NLINES-1:0];
        eelc_pkg::OFS_PEND:  pend_clr  = bus_req.wdata[NLINES-1:0];
        eelc_pkg::OFS_SMASK: smask_nxt = bus_req.wdata[NLINES-1:0];
        default: begin
          if (sel_hit(bus_req.addr) && wi < NWORD) begin
            for (int k = 0; k < eelc_pkg::SEL_PER_WD; k++) begin
              sel_nxt[wi*eelc_pkg::SEL_PER_WD+k] = bus_req.wdata[k*eelc_pkg::SEL_LANE +: SELW];
            end
          end
        end
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        eelc_pkg::OFS_IMASK: rdata_nxt = zx(imask_r);
        eelc_pkg::OFS_EMASK: rdata_nxt = zx(emask_r);
        eelc_pkg::OFS_RTRIG: rdata_nxt = zx(rtrig_r);
        eelc_pkg::OFS_FTRIG: rdata_nxt = zx(ftrig_r);
        eelc_pkg::OFS_PEND:  rdata_nxt = zx(pend_r);
        eelc_pkg::OFS_SSTAT: rdata_nxt = zx(sstat_r);
        eelc_pkg::OFS_SMASK: rdata_nxt = zx(smask_r);
        default: begin
          if (sel_hit(bus_req.addr) && wi < NWORD) begin
            for (int k = 0; k < eelc_pkg::SEL_PER_WD; k++) begin
              rdata_nxt[k*eelc_pkg::SEL_LANE +: SELW] = sel_r[wi*eelc_pkg::SEL_PER_WD+k];
            end
          end
        end
      endcase
    end
    // a masked line never sets pending; set is applied after clear so it wins
    pend_nxt     = (pend_r & ~pend_clr) | (hit & imask_r);
    sstat_nxt    = (rd_sstat ? '0 : sstat_r) | hit;
    irq_line_nxt = pend_nxt & imask_nxt;
    evt_nxt      = hit & emask_r;
    wake_nxt     = |(hit & (imask_r | emask_r));
    irq_nxt      = |(sstat_nxt & smask_nxt);
  end

  // state registers; selector i starts on pin i
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      imask_r  <= eelc_pkg::IMASK_RST[NLINES-1:0];
      emask_r  <= eelc_pkg::EMASK_RST[NLINES-1:0];
      rtrig_r  <= eelc_pkg::TRIG_RST[NLINES-1:0];
      ftrig_r  <= eelc_pkg::TRIG_RST[NLINES-1:0];
      smask_r  <= eelc_pkg::SMASK_RST[NLINES-1:0];
      pend_r   <= '0;
      sstat_r  <= '0;
      rdata    <= '0;
      irq_line <= '0;
      evt_req  <= '0;
      wake_req <= 1'b0;
      irq      <= 1'b0;
      for (int i = 0; i < NEXT; i++) begin
        sel_r[i] <= SELW'(i);
      end
    end else begin
      imask_r  <= imask_nxt;
      emask_r  <= emask_nxt;
      rtrig_r  <= rtrig_nxt;
      ftrig_r  <= ftrig_nxt;
      smask_r  <= smask_nxt;
      pend_r   <= pend_nxt;
      sstat_r  <= sstat_nxt;
      rdata    <= rdata_nxt;
      irq_line <= irq_line_nxt;
      evt_req  <= evt_nxt;
      wake_req <= wake_nxt;
      irq      <= irq_nxt;
      sel_r    <= sel_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic              wr_pend;
  logic [NLINES-1:0] hit_im;
  logic [NLINES-1:0] hit_em;
  logic              hit_wk;
  // helper terms, so that $past only ever looks at plain signals
  assign wr_pend = bus_req.wr && (bus_req.addr == eelc_pkg::OFS_PEND);
  assign hit_im  = hit & imask_r;
  assign hit_em  = hit & emask_r;
  assign hit_wk  = |(hit & (imask_r | emask_r));

  a_pend_sets: assert property (
    |hit_im |=> ((pend_r & $past(hit_im)) == $past(hit_im)))
    else $error("pending flag not set after unmasked edge");

  a_pend_holds: assert property (
    !wr_pend |=> (($past(pend_r) & ~pend_r) == '0))
    else $error("pending flag dropped without a clear write");

  a_pend_clear: assert property (
    wr_pend |=> ((pend_r & $past(bus_req.wdata[NLINES-1:0]) & ~$past(hit)) == '0))
    else $error("pending flag survived its clear write");

  a_irq_masked: assert property (
    irq_line == (pend_r & imask_r))
    else $error("interrupt line disagrees with pending and mask");

  a_evt_masked: assert property (
    ##1 ((evt_req & ~$past(emask_r)) == '0))
    else $error("event request on a masked line");

  a_int_rise: assert property (
    (int_src[0] && !int_prev_r[0] && rtrig_r[NEXT] && imask_r[NEXT]) |=> pend_r[NEXT])
    else $error("internal rising edge missed");

  a_ext_capture: assert property (
    ((rise_s2[0] != rise_s3[0]) && rtrig_r[0] && imask_r[0]) |=> ##1 irq_line[0])
    else $error("captured external edge did not reach the interrupt line");

  a_wake_edge: assert property (
    hit_wk |=> wake_req)
    else $error("wake request missing after enabled edge");

  a_wake_quiet: assert property (
    !hit_wk |=> !wake_req)
    else $error("wake request without an enabled edge");

  a_sstat_read: assert property (
    (rd_sstat && !(|hit)) |=> (sstat_r == '0) && (rdata == zx($past(sstat_r))))
    else $error("status read did not return and clear");

  a_irq_level: assert property (
    ##1 (irq == |(sstat_r & smask_r)))
    else $error("summary interrupt level wrong");

  a_evt_edge: assert property (
    |hit_em |=> ((evt_req & $past(hit_em)) == $past(hit_em)))
    else $error("event request missing after enabled edge");

  a_pend_masked: assert property (
    ##1 ((pend_r & ~$past(pend_r) & ~$past(imask_r)) == '0))
    else $error("pending flag set on a masked line");

  a_sstat_sticky: assert property (
    !rd_sstat |=> (($past(sstat_r) & ~sstat_r) == '0))
    else $error("status bit dropped without a status read");

  a_rdata_idle: assert property (
    !bus_req.rd |=> (rdata == '0))
    else $error("read data not zero outside a read answer");

  a_int_fall: assert property (
    (!int_src[0] && int_prev_r[0] && ftrig_r[NEXT] && emask_r[NEXT]) |=> evt_req[NEXT])
    else $error("internal falling edge missed");

  c_ext_pend: cover property ((rise_s2[0] != rise_s3[0]) && rtrig_r[0] ##2 irq_line[0]);
  c_int_fall: cover property (!int_src[0] && int_prev_r[0] && ftrig_r[NEXT] && emask_r[NEXT]);
  c_clear_race: cover property (wr_pend && |(hit & imask_r & bus_req.wdata[NLINES-1:0]));
  c_wake: cover property (wake_req && irq);
  c_pend_clear: cover property (wr_pend && |(pend_r & bus_req.wdata[NLINES-1:0]));

endmodule

//--- eelc_pkg.sv
package eelc_pkg;

  // line counts and widths
  localparam int NLINES_DEF = 24;
  localparam int NEXT_DEF   = 16;
  localparam int NPINS_DEF  = 55;
  localparam int SELW       = 6;
  localparam int SEL_PER_WD = 4;
  localparam int SEL_LANE   = 8;
  localparam int AW         = 8;
  localparam int DW         = 32;

  // register byte addresses
  localparam logic [AW-1:0] OFS_IMASK = 8'h00;
  localparam logic [AW-1:0] OFS_EMASK = 8'h04;
  localparam logic [AW-1:0] OFS_RTRIG = 8'h08;
  localparam logic [AW-1:0] OFS_FTRIG = 8'h0C;
  localparam logic [AW-1:0] OFS_PEND  = 8'h10;
  localparam logic [AW-1:0] OFS_SSTAT = 8'h14;
  localparam logic [AW-1:0] OFS_SMASK = 8'h18;
  localparam logic [AW-1:0] OFS_SEL0  = 8'h20;
  localparam logic [AW-1:0] OFS_SEL3  = 8'h2C;

  // values after reset
  localparam logic [DW-1:0] IMASK_RST = 32'h00000000;
  localparam logic [DW-1:0] EMASK_RST = 32'h00000000;
  localparam logic [DW-1:0] TRIG_RST  = 32'h00000000;
  localparam logic [DW-1:0] SMASK_RST = 32'h00000000;

  // register port request, one cycle per access
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } eelc_bus_req_t;

endpackage

//--- eelc_src_model.sv
`timescale 1ns/1ps

// stands in for the pins and the internal peripherals feeding the lines
module eelc_src_model (
  // clock
  input  wire logic        clk,
  // commands from the bench
  input  wire logic        pulse_go,
  input  wire logic [5:0]  pulse_pin,
  input  wire logic [7:0]  int_lvl,
  // source signals
  output logic [54:0]      gpio_in,
  output logic [7:0]       int_src
);
  initial gpio_in = '0;
  initial int_src = '0;

  // internal sources are synchronous levels, so they move only after an edge
  always @(posedge clk) int_src <= int_lvl;

  // a 3 ns pin pulse, shorter than a clock, that a sampling detector would miss
  always @(posedge clk) begin
    if (pulse_go) begin
      #2 gpio_in[pulse_pin] = 1'b1;
      #3 gpio_in[pulse_pin] = 1'b0;
    end
  end
endmodule

//--- edge_event_line_controller_tb_top.sv
`timescale 1ns/1ps

module edge_event_line_controller_tb_top;
  logic                    clk, nrst, pulse_go, wake_req, irq, wk_seen;
  logic [5:0]              pulse_pin;
  logic [7:0]              int_lvl, int_src;
  logic [54:0]             gpio_in;
  logic [31:0]             rdata, rv;
  logic [23:0]             irq_line, evt_req, ev_seen;
  eelc_pkg::eelc_bus_req_t bus_req;
  int                      error_cnt, n_tests;

  eelc_top DUT (.clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .gpio_in(gpio_in), .int_src(int_src), .irq_line(irq_line), .evt_req(evt_req),
    .wake_req(wake_req), .irq(irq));
  eelc_src_model SRC (.clk(clk), .pulse_go(pulse_go), .pulse_pin(pulse_pin),
    .int_lvl(int_lvl), .gpio_in(gpio_in), .int_src(int_src));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one strobe cycle; read data is picked up in the following cycle only
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    #1 rv = rdata;
  endtask

  // pulses last one cycle, so gather them cycle by cycle
  task automatic watch(input int n);
    ev_seen = '0;
    wk_seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 ev_seen |= evt_req;
      wk_seen |= wake_req;
    end
  endtask

  // mode bit 0 selects rising, bit 1 falling
  function automatic logic hit_exp(input logic [1:0] mode, input logic rise);
    return rise ? mode[0] : mode[1];
  endfunction

  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // the run needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end

  initial begin
    int         L, k, p;
    logic [1:0] mode;
    logic       msk, rise, hit;
    logic [31:0] ex;
    error_cnt = 0;
    n_tests = 0;
    nrst = 1'b0;
    bus_req = '0;
    pulse_go = 1'b0;
    pulse_pin = '0;
    int_lvl = '0;
    void'($urandom(32'hBF79));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 1, eelc_pkg::OFS_IMASK, 32'h0);
    chk(rv, eelc_pkg::IMASK_RST);
    bus(0, 1, 8'h40, 32'h0);
    chk(rv, 32'h0);
    bus(1, 0, eelc_pkg::OFS_SMASK, 32'h00FFFFFF);
    // internal lines: every trigger mode, one masked case
    for (int i = 0; i < 8; i++) begin
      // line 16 is kept for the rising and falling corner cases, so its level is known
      L = (i == 1 || i == 2) ? 16 : 17 + $urandom % 7;
      mode = i[1:0];
      msk = (i == 5);
      bus(1, 0, eelc_pkg::OFS_RTRIG, {31'h0, mode[0]} << L);
      bus(1, 0, eelc_pkg::OFS_FTRIG, {31'h0, mode[1]} << L);
      bus(1, 0, eelc_pkg::OFS_IMASK, msk ? 32'h0 : 32'h1 << L);
      bus(1, 0, eelc_pkg::OFS_EMASK, msk ? 32'h0 : 32'h1 << L);
      rise = ~int_lvl[L-16];
      @(posedge clk);
      int_lvl[L-16] <= rise;
      watch(6);
      hit = hit_exp(mode, rise);
      ex = {31'h0, hit & ~msk} << L;
      chk(ev_seen, ex);
      chk(wk_seen, hit & ~msk);
      chk(irq_line, ex);
      chk(irq, hit);
      bus(0, 1, eelc_pkg::OFS_PEND, 32'h0);
      chk(rv, ex);
      bus(0, 1, eelc_pkg::OFS_SSTAT, 32'h0);
      chk(rv, {31'h0, hit} << L);
      bus(0, 1, eelc_pkg::OFS_SSTAT, 32'h0);
      chk(rv, 32'h0);
      chk(irq_line, ex);
      bus(1, 0, eelc_pkg::OFS_PEND, 32'h1 << L);
      @(posedge clk);
      #1 chk(irq_line, 32'h0);
    end
    // external lines: narrow pulse on a selected pin
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 0 : $urandom % 16;
      p = (i == 0) ? k : $urandom % 55;
      bus(1, 0, 8'(eelc_pkg::OFS_SEL0 + 4 * (k / 4)), 32'(p) << (8 * (k % 4)));
      bus(0, 1, 8'(eelc_pkg::OFS_SEL0 + 4 * (k / 4)), 32'h0);
      chk(rv, 32'(p) << (8 * (k % 4)));
      repeat (6) @(posedge clk);
      bus(1, 0, eelc_pkg::OFS_RTRIG, i[0] ? 32'h0 : 32'h1 << k);
      bus(1, 0, eelc_pkg::OFS_FTRIG, i[0] ? 32'h1 << k : 32'h0);
      bus(1, 0, eelc_pkg::OFS_IMASK, 32'h1 << k);
      bus(1, 0, eelc_pkg::OFS_PEND, 32'h00FFFFFF);
      @(posedge clk);
      pulse_pin <= 6'(p);
      pulse_go <= 1'b1;
      @(posedge clk);
      pulse_go <= 1'b0;
      watch(8);
      chk(irq_line, 32'h1 << k);
      bus(0, 1, eelc_pkg::OFS_PEND, 32'h0);
      chk(rv, 32'h1 << k);
    end
    // corner: an edge sampled in the very cycle of the clear write keeps pending set
    bus(1, 0, eelc_pkg::OFS_PEND, 32'h00FFFFFF);
    bus(1, 0, eelc_pkg::OFS_RTRIG, 32'h1 << 16);
    bus(1, 0, eelc_pkg::OFS_IMASK, 32'h1 << 16);
    @(posedge clk);
    int_lvl[0] <= 1'b1;
    bus(1, 0, eelc_pkg::OFS_PEND, 32'h1 << 16);
    bus(0, 1, eelc_pkg::OFS_PEND, 32'h0);
    chk(rv, 32'h1 << 16);
    end_sim;
  end
endmodule
